/* rtl/dsc_top.sv */
// Digital system configuration register with APB access and the frame timing it steers.
// Assumes frame events and check results come from frame logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dsc_top
#(
  parameter int WDT_TIMEOUT_CYC = dsc_pkg::DSC_WDT_DEF_CYC
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output dsc_pkg::dsc_cfg_t  cfg,
  input  wire logic          frame_start,
  input  wire logic          last_bit_out,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_crc_ok,
  output logic               cmd_accept,
  output logic               done_n,
  output logic               dout_oe,
  output logic               wdt_timeout
);

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  logic [7:0]  cfg_ff;
  logic [7:0]  nxt_cfg;
  logic [31:0] nxt_prdata;
  logic        hit;
  logic        access;
  logic        setup;
  logic        wr_en;
  logic        rd_load;

  assign hit     = (paddr == {24'h000000, dsc_pkg::DSC_CFG_ADDR});
  assign access  = psel && penable;
  assign setup   = psel && !penable;
  assign wr_en   = access && pwrite && hit && pstrb[0];
  assign rd_load = setup && !pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = access && !hit;

  // Only the low byte lane reaches the register; the upper lanes are dropped.
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (wr_en)
    begin
      nxt_cfg = pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_ff <= dsc_pkg::DSC_CFG_RESET;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Read data is loaded in the setup cycle, so it stands through the access phase
  // with no wait state; any other setup cycle clears it.
  always_comb
  begin
    nxt_prdata = prdata;
    if (rd_load)
    begin
      nxt_prdata = {24'h000000, cfg_ff};
    end
    else if (setup)
    begin
      nxt_prdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h00000000;
    end
    else
    begin
      prdata <= nxt_prdata;
    end
  end

  assign cfg.watchdog_enable_bit = cfg_ff[dsc_pkg::DSC_WDT_BIT];
  assign cfg.crc_all_bits        = cfg_ff[dsc_pkg::DSC_MODE_BIT];
  assign cfg.done_delay_sel      = cfg_ff[dsc_pkg::DSC_DONE_MSB:dsc_pkg::DSC_DONE_LSB];
  assign cfg.float_delay_sel     = cfg_ff[dsc_pkg::DSC_FLT_MSB:dsc_pkg::DSC_FLT_LSB];
  assign cfg.frame_bit_a         = cfg_ff[dsc_pkg::DSC_FRAME_BIT];
  assign cfg.crc_enable          = cfg_ff[dsc_pkg::DSC_CRC_BIT];

  // ****************************************************************
  // Command gating by the check code.
  // ****************************************************************
  // The check result must arrive in the same cycle as its command.
  logic nxt_cmd_accept;

  assign nxt_cmd_accept = cmd_valid && (!cfg.crc_enable || cmd_crc_ok);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_accept <= 1'b0;
    end
    else
    begin
      cmd_accept <= nxt_cmd_accept;
    end
  end

  // ****************************************************************
  // Done strobe and output float timing.
  // ****************************************************************
  // Both timers start on the last bit; each code rounds up to whole clocks, at least one.
  logic done_fire;
  logic float_fire;

  dsc_delay u_done_dly
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (last_bit_out),
    .cycles (dsc_pkg::dsc_sel_to_cyc(cfg.done_delay_sel)),
    .fire   (done_fire)
  );

  dsc_delay u_float_dly
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (last_bit_out),
    .cycles (dsc_pkg::dsc_sel_to_cyc(cfg.float_delay_sel)),
    .fire   (float_fire)
  );

  // The done strobe stays low until the next frame opens.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_n <= 1'b1;
    end
    else if (frame_start)
    begin
      done_n <= 1'b1;
    end
    else if (done_fire)
    begin
      done_n <= 1'b0;
    end
  end

  // The data output is driven from frame start until the float delay runs out.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_oe <= 1'b0;
    end
    else if (frame_start)
    begin
      dout_oe <= 1'b1;
    end
    else if (float_fire)
    begin
      dout_oe <= 1'b0;
    end
  end

  // ****************************************************************
  // Watchdog timeout counter.
  // ****************************************************************
  // A frame restarts the count, so frames no more than WDT_TIMEOUT_CYC cycles apart never time out.
  logic [31:0] wdt_cnt_ff;
  logic        wdt_clear;
  logic        wdt_expire;

  assign wdt_clear  = !cfg.watchdog_enable_bit || frame_start;
  assign wdt_expire = (wdt_cnt_ff >= 32'(WDT_TIMEOUT_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_cnt_ff  <= 32'h00000000;
      wdt_timeout <= 1'b0;
    end
    else
    begin
      wdt_timeout <= 1'b0;
      if (wdt_clear)
      begin
        wdt_cnt_ff <= 32'h00000000;
      end
      else if (wdt_expire)
      begin
        wdt_cnt_ff  <= 32'h00000000;
        wdt_timeout <= 1'b1;
      end
      else
      begin
        wdt_cnt_ff <= wdt_cnt_ff + 32'h00000001;
      end
    end
  end

endmodule // dsc_top
`default_nettype wire

/* rtl/dsc_pkg.sv */
// Package for the digital system configuration block: register map, fields, timing.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
//
// Operation
// - Bit 7 set runs the watchdog timeout counter, clear stops it, and it resets to 0.
// - Bit 6 at 0 limits the check code to device words, at 1 it covers every frame bit.
// - Bits 5:4 select at least 6, 8, 10 or 12 ns before the done strobe, default 11.
// - Bits 3:2 select at least 6, 8, 10 or 12 ns before the data output floats, default 11.
// - Bit 0 set adds a check word to frames in both directions, default off.
// - With the check code on, only commands that pass the check are acted upon.
// - The register sits at address 0Ch and reads 3Ch after reset.
package dsc_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0]  DSC_CFG_ADDR  = 8'h0C;
  localparam logic [7:0]  DSC_CFG_RESET = 8'h3C;
  localparam int          DSC_WDT_BIT   = 7;
  localparam int          DSC_MODE_BIT  = 6;
  localparam int          DSC_DONE_MSB  = 5;
  localparam int          DSC_DONE_LSB  = 4;
  localparam int          DSC_FLT_MSB   = 3;
  localparam int          DSC_FLT_LSB   = 2;
  localparam int          DSC_FRAME_BIT = 1;
  localparam int          DSC_CRC_BIT   = 0;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int          DSC_CLK_MHZ     = 25;
  localparam int          DSC_DLY00_NS    = 6;
  localparam int          DSC_DLY01_NS    = 8;
  localparam int          DSC_DLY10_NS    = 10;
  localparam int          DSC_DLY11_NS    = 12;
  localparam int          DSC_WDT_DEF_CYC = 1024;
  localparam int          DSC_CNT_W       = 4;

  typedef struct packed {
    logic       watchdog_enable_bit;
    logic       crc_all_bits;
    logic [1:0] done_delay_sel;
    logic [1:0] float_delay_sel;
    logic       frame_bit_a;
    logic       crc_enable;
  } dsc_cfg_t;

  // Least time in ns to whole clock cycles, rounded up, never below one.
  function automatic logic [DSC_CNT_W-1:0] dsc_ns_to_cyc(input int ns);
    int cyc;
    cyc = (ns * DSC_CLK_MHZ + 999) / 1000;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return cyc[DSC_CNT_W-1:0];
  endfunction

  // Delay code to cycle count; code 11 takes the longest figure.
  function automatic logic [DSC_CNT_W-1:0] dsc_sel_to_cyc(input logic [1:0] sel);
    logic [DSC_CNT_W-1:0] r;
    r = dsc_ns_to_cyc(DSC_DLY11_NS);
    unique case (sel)
      2'h0: r = dsc_ns_to_cyc(DSC_DLY00_NS);
      2'h1: r = dsc_ns_to_cyc(DSC_DLY01_NS);
      2'h2: r = dsc_ns_to_cyc(DSC_DLY10_NS);
      2'h3: r = dsc_ns_to_cyc(DSC_DLY11_NS);
    endcase
    return r;
  endfunction

endpackage

/* rtl/dsc_delay.sv */
// Programmable one-shot delay: fires one pulse a given number of cycles after start.
// Assumes start and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dsc_delay
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        start,
  input  wire logic [dsc_pkg::DSC_CNT_W-1:0] cycles,
  output logic                             fire
);

  logic [dsc_pkg::DSC_CNT_W-1:0] cnt_ff;
  logic                          busy_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      fire    <= 1'b0;
    end
    else
    begin
      fire <= 1'b0;
      if (start)
      begin
        cnt_ff  <= cycles - 4'h1;
        busy_ff <= (cycles > 4'h1);
        fire    <= (cycles <= 4'h1);
      end
      else if (busy_ff)
      begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff <= 4'h1)
        begin
          busy_ff <= 1'b0;
          fire    <= 1'b1;
        end
      end
    end
  end

endmodule // dsc_delay
`default_nettype wire

/* testbench/dsc_top_sva.sv */
// Checker for the configuration block, bound to its top module.
// Assumes one clock with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dsc_top_chk
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire dsc_pkg::dsc_cfg_t cfg,
  input wire logic              frame_start,
  input wire logic              last_bit_out,
  input wire logic              cmd_valid,
  input wire logic              cmd_crc_ok,
  input wire logic              cmd_accept,
  input wire logic              done_n,
  input wire logic              dout_oe,
  input wire logic              wdt_timeout
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_last;
    last_bit_out && !frame_start ##1 !frame_start;
  endsequence
  property p_wen;
    psel && penable && pwrite && paddr == 32'h0000000C && pstrb[0]
      |=> cfg == $past(pwdata[7:0]);
  endproperty
  property p_rst;
    $rose(rst_n) |-> cfg == 8'h3C;
  endproperty
  property p_err;
    psel && penable && paddr != 32'h0000000C |-> pslverr;
  endproperty
  property p_acc;
    cmd_valid && (!cfg.crc_enable || cmd_crc_ok) |=> cmd_accept;
  endproperty
  property p_rej;
    cmd_valid && cfg.crc_enable && !cmd_crc_ok |=> !cmd_accept;
  endproperty
  property p_end;
    s_last |=> !done_n && !dout_oe;
  endproperty
  property p_hold;
    !done_n && !frame_start |=> !done_n;
  endproperty
  property p_open;
    frame_start && !last_bit_out |=> dout_oe && done_n;
  endproperty
  property p_wdt;
    !cfg.watchdog_enable_bit |=> !wdt_timeout;
  endproperty
  a_wen: assert property (p_wen) else $error("write lost");
  a_rst: assert property (p_rst) else $error("bad reset value");
  a_err: assert property (p_err) else $error("no slave error");
  a_acc: assert property (p_acc) else $error("command dropped");
  a_rej: assert property (p_rej) else $error("bad command taken");
  a_end: assert property (p_end) else $error("late frame end");
  a_hold: assert property (p_hold) else $error("done not held");
  a_open: assert property (p_open) else $error("frame not opened");
  a_wdt: assert property (p_wdt) else $error("timeout while off");
endmodule // dsc_top_chk
bind dsc_top dsc_top_chk u_chk (.*);
`default_nettype wire

/* testbench/dsc_host.sv */
// Model of the serial host: opens and closes frames and sends commands.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module dsc_host
(
  input  wire logic clk,
  output logic      frame_start,
  output logic      last_bit_out,
  output logic      cmd_valid,
  output logic      cmd_crc_ok
);
  initial {frame_start, last_bit_out, cmd_valid, cmd_crc_ok} = 4'h0;
  task automatic frame(input int len);
    frame_start <= 1'b1;
    @(posedge clk) frame_start <= 1'b0;
    repeat (len) @(posedge clk);
    last_bit_out <= 1'b1;
    @(posedge clk) last_bit_out <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // The check flag is inverted once the command is gone, never left stale.
  task automatic cmd(input logic ok);
    cmd_valid <= 1'b1;
    cmd_crc_ok <= ok;
    @(posedge clk) cmd_valid <= 1'b0;
    cmd_crc_ok <= !ok;
  endtask
endmodule // dsc_host
`default_nettype wire

/* testbench/digital_system_config_test.sv */
// Testbench for the configuration block with the host model.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module digital_system_config_test;
  typedef struct packed
  {
    logic [31:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] rd; logic e; logic [7:0] c;
  } dsc_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic frame_start, last_bit_out, cmd_valid, cmd_crc_ok, cmd_accept, done_n, dout_oe;
  logic wdt_timeout;
  dsc_pkg::dsc_cfg_t cfg;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_wdt = 0, w0;
  dsc_row_t rows [5] = '{'{32'hC, 8'hFF, 4'hF, 8'hFF, 1'b0, 8'hFF},
    '{32'hC, 8'h5A, 4'hE, 8'hFF, 1'b0, 8'hFF}, '{32'h10, 8'h00, 4'hF, 8'h00, 1'b1, 8'hFF},
    '{32'hC, 8'h00, 4'h1, 8'h00, 1'b0, 8'h00}, '{32'hC, 8'h3C, 4'h1, 8'h3C, 1'b0, 8'h3C}};
  dsc_top #(.WDT_TIMEOUT_CYC(8)) u_dut (.*);
  dsc_host u_host (.*);
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_wdt += (wdt_timeout === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, {24'hFFFFFF, rows[i].d}, rows[i].s);
      apb(1'b0, rows[i].a, 32'h0, 4'hF);
      chk(rd, {24'h0, rows[i].rd});
      chk({31'h0, er}, {31'h0, rows[i].e});
      chk({24'h0, cfg}, {24'h0, rows[i].c});
    end
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 32'hC, {26'h0, k[1:0], k[1:0], 2'h0}, 4'h1);
      u_host.frame(5);
      chk({30'h0, done_n, dout_oe}, 32'h0);
    end
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 32'hC, {31'h0, k != 0}, 4'h1);
      u_host.cmd(k == 1);
      @(negedge clk);
      chk({31'h0, cmd_accept}, {31'h0, k != 2});
      @(posedge clk);
    end
    apb(1'b1, 32'hC, 32'h80, 4'h1);
    w0 = n_wdt;
    repeat (20) @(posedge clk);
    chk({31'h0, (n_wdt - w0) inside {[2:3]}}, 32'h1);
    apb(1'b1, 32'hC, 32'h0, 4'h1);
    w0 = n_wdt;
    repeat (20) @(posedge clk);
    chk(n_wdt - w0, 32'h0);
    rst_n <= 1'b0;
    @(posedge clk);
    chk({24'h0, cfg}, 32'h3C);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 32'hC, 32'h0, 4'hF);
    chk(rd, 32'h3C);
    wrap_up();
  end
endmodule // digital_system_config_test
`default_nettype wire
